// ===== flow_master_model.sv
// Bus master model that issues register reads and refused writes
module flow_master_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        wr_reject,
    output logic             rd_en,
    output logic             wr_en,
    output logic      [15:0] reg_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        reg_addr = 16'h0000;
    end

    // One read; answer taken in the single cycle it stands
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(negedge sys_clk);
        rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        d = rd_data;
        v = rd_valid;
        rd_en = 1'b0;
        reg_addr = ~a;
    endtask

    // Deliberate write attempt, expected to be refused
    task automatic wr(output logic rej);
        @(negedge sys_clk);
        wr_en = 1'b1;
        @(negedge sys_clk);
        rej = wr_reject;
        wr_en = 1'b0;
    endtask
endmodule

// ===== flow_regs_pkg.sv
// Constants, offsets and states of the pressure and flow input register bank
package flow_regs_pkg;
    // Input register offsets
    localparam logic [15:0] IR_PRESSURE   = 16'h0001;
    localparam logic [15:0] IR_FLOW_HI    = 16'h0002;
    localparam logic [15:0] IR_FLOW_LO    = 16'h0003;
    localparam logic [15:0] IR_SPEED      = 16'h0004;
    localparam logic [15:0] IR_LEVEL      = 16'h0005;
    localparam logic [15:0] IR_MAXFLOW_HI = 16'h0006;
    localparam logic [15:0] IR_MAXFLOW_LO = 16'h0007;
    localparam logic [15:0] IR_SPAN       = 16'h0008;
    localparam logic [15:0] IR_ALARM      = 16'h0009;
    localparam logic [15:0] IR_FB_LOST    = 16'h000A;
    localparam logic [15:0] IR_SENS_FAIL  = 16'h000B;
    localparam logic [15:0] IR_RSVD_FIRST = 16'h000C;
    localparam logic [15:0] IR_RSVD_LAST  = 16'h0014;
    // Value limits
    localparam logic [15:0] SPEED_MAX     = 16'h012C;
    localparam logic [15:0] LEVEL_MAX     = 16'h03E8;
    localparam logic [15:0] PRESSURE_FULL = 16'hFFFF;
    localparam logic [15:0] SPEED_MODE_ON = 16'h0001;
    localparam logic [15:0] READ_ZERO     = 16'h0000;
    // Square root engine
    localparam int          ROOT_BITS     = 8;
    localparam logic [2:0]  ROOT_TOP_BIT  = 3'h7;
    // Red LED flash half period
    localparam int          FLASH_HALF_MS = 250;
    localparam int          CLK_MHZ       = 125;
    localparam int          FLASH_CYCLES  = FLASH_HALF_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ROOT = 3'b010,
        ST_CALC = 3'b100
    } calc_state_t;
endpackage

// ===== pressure_flow_input_registers.sv
// Read-only input register bank: flow, speed, level, limit and fault status
//
// What this block does
// - Volume flow split: high word 2, low 3
// - Fan coefficient set: flow is coefficient times root
// - Otherwise flow is duct area times speed
// - Speed in tenths, 0..300, only in mode
// - Output level in tenths percent, 0..1000
// - Maximum flow pair from coefficient or duct area
// - Span flag set when outside span limits
// - Alarm flag set when outside alarm limits
// - Both flags inactive during automatic tuning
// - Feedback lost status bit, 1 when lost
// - Sensor fault status bit, 1 when failed
// - Red LED flashes on feedback or sensor fault
module pressure_flow_input_registers
    import flow_regs_pkg::*;
#(
    parameter int FLASH_HALF = flow_regs_pkg::FLASH_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] pressure_in,
    input  wire logic [15:0] speed_in,
    input  wire logic [15:0] level_in,
    input  wire logic [15:0] fan_coeff,
    input  wire logic [15:0] duct_area,
    input  wire logic [15:0] speed_mode,
    input  wire logic [15:0] span_press_lo,
    input  wire logic [15:0] span_press_hi,
    input  wire logic [31:0] span_flow_lo,
    input  wire logic [31:0] span_flow_hi,
    input  wire logic [15:0] span_speed_lo,
    input  wire logic [15:0] span_speed_hi,
    input  wire logic [15:0] alarm_press_lo,
    input  wire logic [15:0] alarm_press_hi,
    input  wire logic [31:0] alarm_flow_lo,
    input  wire logic [31:0] alarm_flow_hi,
    input  wire logic [15:0] alarm_speed_lo,
    input  wire logic [15:0] alarm_speed_hi,
    input  wire logic        autotune_busy,
    input  wire logic        feedback_lost,
    input  wire logic        sensor_failed,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             wr_reject,
    output logic             red_led
);
    import flow_regs_pkg::*;

    // Measured values
    logic [15:0] pressure;
    logic [15:0] speed;
    logic [15:0] level;
    logic [15:0] next_pressure;
    logic [15:0] next_speed;
    logic [15:0] next_level;
    logic        speed_on;

    assign speed_on = (speed_mode == SPEED_MODE_ON);

    always_comb begin
        next_pressure = pressure_in;
        next_speed    = READ_ZERO;
        if (speed_on) begin
            next_speed = (speed_in > SPEED_MAX) ? SPEED_MAX : speed_in;
        end
        next_level = (level_in > LEVEL_MAX) ? LEVEL_MAX : level_in;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pressure <= 16'h0000;
            speed    <= 16'h0000;
            level    <= 16'h0000;
        end else begin
            pressure <= next_pressure;
            speed    <= next_speed;
            level    <= next_level;
        end
    end

    // Square root of pressure, one result bit per cycle, then flow product
    calc_state_t state;
    calc_state_t next_state;
    logic [7:0]  root;
    logic [7:0]  next_root;
    logic [2:0]  bit_idx;
    logic [2:0]  next_bit_idx;
    logic [15:0] root_src;
    logic [15:0] next_root_src;
    logic [31:0] flow;
    logic [31:0] next_flow;
    logic [31:0] max_flow;
    logic [31:0] next_max_flow;
    logic [7:0]  trial;
    logic [15:0] trial_sq;
    logic [7:0]  full_root;

    assign trial     = root | (8'h01 << bit_idx);
    assign trial_sq  = 16'(trial) * 16'(trial);
    assign full_root = 8'hFF;

    always_comb begin
        next_state    = state;
        next_root     = root;
        next_bit_idx  = bit_idx;
        next_root_src = root_src;
        next_flow     = flow;
        next_max_flow = max_flow;
        case (state)
            ST_IDLE: begin
                next_root     = 8'h00;
                next_bit_idx  = ROOT_TOP_BIT;
                next_root_src = pressure;
                next_state    = ST_ROOT;
            end
            ST_ROOT: begin
                if (trial_sq <= root_src) begin
                    next_root = trial;
                end
                next_bit_idx = bit_idx - 3'h1;
                if (bit_idx == 3'h0) begin
                    next_state = ST_CALC;
                end
            end
            ST_CALC: begin
                if (fan_coeff != 16'h0000) begin
                    next_flow     = {8'h00, 24'(fan_coeff) * 24'(root)};
                    next_max_flow = {8'h00, 24'(fan_coeff) * 24'(full_root)};
                end else begin
                    next_flow     = {7'h00, 25'(duct_area) * 25'(speed[8:0])};
                    next_max_flow = {7'h00, 25'(duct_area) * 25'(SPEED_MAX[8:0])};
                end
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state    <= ST_IDLE;
            root     <= 8'h00;
            bit_idx  <= 3'h0;
            root_src <= 16'h0000;
            flow     <= 32'h0000_0000;
            max_flow <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            root     <= next_root;
            bit_idx  <= next_bit_idx;
            root_src <= next_root_src;
            flow     <= next_flow;
            max_flow <= next_max_flow;
        end
    end

    // Limit flags and fault status
    logic span_flag;
    logic alarm_flag;
    logic fb_stat;
    logic fail_stat;
    logic next_span_flag;
    logic next_alarm_flag;
    logic span_out;
    logic alarm_out;

    always_comb begin
        span_out = (pressure < span_press_lo) || (pressure > span_press_hi)
                || (flow < span_flow_lo) || (flow > span_flow_hi)
                || (speed_on && ((speed < span_speed_lo) || (speed > span_speed_hi)));
        alarm_out = (pressure < alarm_press_lo) || (pressure > alarm_press_hi)
                 || (flow < alarm_flow_lo) || (flow > alarm_flow_hi)
                 || (speed_on && ((speed < alarm_speed_lo) || (speed > alarm_speed_hi)));
        next_span_flag  = span_out && !autotune_busy;
        next_alarm_flag = alarm_out && !autotune_busy;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            span_flag  <= 1'b0;
            alarm_flag <= 1'b0;
            fb_stat    <= 1'b0;
            fail_stat  <= 1'b0;
        end else begin
            span_flag  <= next_span_flag;
            alarm_flag <= next_alarm_flag;
            fb_stat    <= feedback_lost;
            fail_stat  <= sensor_failed;
        end
    end

    // Red LED flash
    logic [31:0] flash_cnt;
    logic [31:0] next_flash_cnt;
    logic        next_red_led;

    always_comb begin
        next_flash_cnt = 32'h0000_0000;
        next_red_led   = 1'b0;
        if (fb_stat || fail_stat) begin
            next_red_led   = red_led;
            next_flash_cnt = flash_cnt + 32'h0000_0001;
            if (flash_cnt >= 32'(FLASH_HALF)) begin
                next_flash_cnt = 32'h0000_0001;
                next_red_led   = !red_led;
            end
            if (!red_led && flash_cnt == 32'h0000_0000) begin
                next_red_led = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flash_cnt <= 32'h0000_0000;
            red_led   <= 1'b0;
        end else begin
            flash_cnt <= next_flash_cnt;
            red_led   <= next_red_led;
        end
    end

    // Register read port
    logic [15:0] next_rd_data;
    logic        next_rd_valid;
    logic        next_wr_reject;

    always_comb begin
        next_rd_valid  = rd_en;
        next_wr_reject = wr_en;
        next_rd_data   = READ_ZERO;
        if (!rd_en) begin
            next_rd_data = READ_ZERO;
        end else if (reg_addr == IR_PRESSURE) begin
            next_rd_data = pressure;
        end else if (reg_addr == IR_FLOW_HI) begin
            next_rd_data = flow[31:16];
        end else if (reg_addr == IR_FLOW_LO) begin
            next_rd_data = flow[15:0];
        end else if (reg_addr == IR_SPEED) begin
            next_rd_data = speed;
        end else if (reg_addr == IR_LEVEL) begin
            next_rd_data = level;
        end else if (reg_addr == IR_MAXFLOW_HI) begin
            next_rd_data = max_flow[31:16];
        end else if (reg_addr == IR_MAXFLOW_LO) begin
            next_rd_data = max_flow[15:0];
        end else if (reg_addr == IR_SPAN) begin
            next_rd_data = {15'h0000, span_flag};
        end else if (reg_addr == IR_ALARM) begin
            next_rd_data = {15'h0000, alarm_flag};
        end else if (reg_addr == IR_FB_LOST) begin
            next_rd_data = {15'h0000, fb_stat};
        end else if (reg_addr == IR_SENS_FAIL) begin
            next_rd_data = {15'h0000, fail_stat};
        end else begin
            next_rd_data = READ_ZERO;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data   <= 16'h0000;
            rd_valid  <= 1'b0;
            wr_reject <= 1'b0;
        end else begin
            rd_data   <= next_rd_data;
            rd_valid  <= next_rd_valid;
            wr_reject <= next_wr_reject;
        end
    end

    // Checks
    sequence flow_hi_read_s;
        rd_en && reg_addr == IR_FLOW_HI;
    endsequence

    sequence root_run_s;
        state == ST_IDLE ##1 state == ST_ROOT [*8] ##1 state == ST_CALC;
    endsequence

    flow_upper_a: assert property (@(posedge sys_clk) disable iff (srst)
        flow_hi_read_s |=> rd_valid && rd_data == $past(flow[31:16]))
        else $error("flow high word read wrong");
    flow_lower_a: assert property (@(posedge sys_clk) disable iff (srst)
        (rd_en && reg_addr == IR_FLOW_LO) |=> rd_data == $past(flow[15:0]))
        else $error("flow low word read wrong");
    root_flow_a: assert property (@(posedge sys_clk) disable iff (srst)
        root_run_s ##0 (fan_coeff != 16'h0000)
        |=> flow == {8'h00, 24'($past(fan_coeff)) * 24'($past(root))})
        else $error("coefficient flow wrong");
    area_flow_a: assert property (@(posedge sys_clk) disable iff (srst)
        (state == ST_CALC && fan_coeff == 16'h0000)
        |=> flow == {7'h00, 25'($past(duct_area)) * 25'($past(speed[8:0]))})
        else $error("duct flow wrong");
    speed_range_a: assert property (@(posedge sys_clk) disable iff (srst)
        !speed_on |=> speed == 16'h0000 ##0 speed <= SPEED_MAX)
        else $error("speed not gated or out of range");
    speed_cap_a: assert property (@(posedge sys_clk) disable iff (srst)
        speed_on |=> speed <= SPEED_MAX)
        else $error("speed above range");
    level_range_a: assert property (@(posedge sys_clk) disable iff (srst)
        level_in > LEVEL_MAX |=> level == LEVEL_MAX)
        else $error("level not clamped");
    max_flow_a: assert property (@(posedge sys_clk) disable iff (srst)
        (state == ST_CALC && fan_coeff != 16'h0000)
        |=> max_flow == {8'h00, 24'($past(fan_coeff)) * 24'(full_root)})
        else $error("maximum flow wrong");
    span_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 span_flag == $past(span_out && !autotune_busy))
        else $error("span flag wrong");
    alarm_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 alarm_flag == $past(alarm_out && !autotune_busy))
        else $error("alarm flag wrong");
    tune_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
        autotune_busy [*2] |-> !span_flag && !alarm_flag)
        else $error("flags active during tuning");
    fb_status_a: assert property (@(posedge sys_clk) disable iff (srst)
        (rd_en && reg_addr == IR_FB_LOST && fb_stat) |=> rd_data == 16'h0001)
        else $error("feedback status read wrong");
    fail_status_a: assert property (@(posedge sys_clk) disable iff (srst)
        sensor_failed |=> fail_stat)
        else $error("sensor fault not reported");
    led_flash_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!fb_stat && !fail_stat) |=> !red_led ##0 flash_cnt == 32'h0000_0000)
        else $error("led lit without fault");
    led_start_a: assert property (@(posedge sys_clk) disable iff (srst)
        ((fb_stat || fail_stat) && flash_cnt == 32'h0000_0000) |=> red_led)
        else $error("led not lit at fault start");
    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
        (rd_en && reg_addr >= IR_RSVD_FIRST && reg_addr <= IR_RSVD_LAST)
        |=> rd_valid && rd_data == READ_ZERO)
        else $error("reserved register not zero");
    write_reject_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_en |=> wr_reject)
        else $error("write not rejected");
endmodule

// ===== pressure_flow_input_registers_tb_top.sv
// Self-checking bench of the pressure and flow input register bank
module pressure_flow_input_registers_tb_top import flow_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, srst, rd_en, wr_en, rd_valid, wr_reject, red_led;
    logic        autotune_busy, feedback_lost, sensor_failed;
    logic [15:0] reg_addr, rd_data, pressure_in, speed_in, level_in;
    logic [15:0] fan_coeff, duct_area, speed_mode;
    logic [15:0] span_press_lo, span_press_hi, span_speed_lo, span_speed_hi;
    logic [15:0] alarm_press_lo, alarm_press_hi, alarm_speed_lo, alarm_speed_hi;
    logic [31:0] span_flow_lo, span_flow_hi, alarm_flow_lo, alarm_flow_hi;
    logic [31:0] lfsr, f;
    logic [15:0] d, e;
    logic        v, rej, seen_on, seen_off;
    int          err_total, n_tests;
    int          cyc = 0;

    pressure_flow_input_registers #(.FLASH_HALF(4)) dut (
        .sys_clk, .srst, .rd_en, .wr_en, .reg_addr, .pressure_in, .speed_in,
        .level_in, .fan_coeff, .duct_area, .speed_mode, .span_press_lo,
        .span_press_hi, .span_flow_lo, .span_flow_hi, .span_speed_lo,
        .span_speed_hi, .alarm_press_lo, .alarm_press_hi, .alarm_flow_lo,
        .alarm_flow_hi, .alarm_speed_lo, .alarm_speed_hi, .autotune_busy,
        .feedback_lost, .sensor_failed, .rd_data, .rd_valid, .wr_reject, .red_led
    );
    flow_master_model m (.sys_clk, .rd_data, .rd_valid, .wr_reject, .rd_en, .wr_en,
        .reg_addr);

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] isqrt(input logic [15:0] p);
        logic [31:0] r;
        r = 32'h0000_0000;
        while ((r + 1) * (r + 1) <= p) r = r + 1;
        return r;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string w);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t %s: saw %h want %h", $time, w, seen, exp);
        end
    endtask

    // Read and compare valid flag and data together
    task automatic rc(input logic [15:0] a, input logic [15:0] x, input string w);
        m.rd(a, d, v);
        check({15'h0000, v, d}, {15'h0000, 1'b1, x}, w);
    endtask

    task automatic wide();
        {span_press_lo, alarm_press_lo, span_speed_lo, alarm_speed_lo} = '0;
        {span_press_hi, alarm_press_hi, span_speed_hi, alarm_speed_hi} = '1;
        {span_flow_lo, alarm_flow_lo} = '0;
        {span_flow_hi, alarm_flow_hi} = '1;
    endtask

    // Wait past a full flow recalculation, then read both flags
    task automatic flags(input logic s, input logic a);
        repeat (30) @(negedge sys_clk);
        rc(IR_SPAN, {15'h0000, s}, "span flag");
        rc(IR_ALARM, {15'h0000, a}, "alarm flag");
    endtask

    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            test_done();
        end
    end

    initial begin
        {srst, err_total, n_tests, lfsr} = {1'b1, 64'h0, 32'hf28a_82cd};
        {autotune_busy, feedback_lost, sensor_failed} = 3'h0;
        {pressure_in, speed_in, level_in, fan_coeff, duct_area, speed_mode} = '0;
        wide();
        repeat (5) @(negedge sys_clk);
        check({13'h0000, rd_valid, wr_reject, red_led, rd_data}, 32'h0000_0000, "reset outputs");
        srst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            lfsr = next_rand(lfsr);
            level_in = (i == 0) ? 16'h03E8 : (i == 1) ? 16'h03E9 : {5'h00, lfsr[10:0]};
            e = (level_in > LEVEL_MAX) ? LEVEL_MAX : level_in;
            rc(IR_LEVEL, e, "output level");
        end
        $display("level test done");
        for (int a = 0; a < 24; a++) if (a == 0 || a > 11) rc(16'(a), 16'h0000, "reserved");
        m.wr(rej);
        check({31'h0000_0000, rej}, 32'h0000_0001, "write refused");
        rc(IR_LEVEL, e, "level kept after write");
        $display("reserved and write test done");
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            fan_coeff = lfsr[15:0] | 16'h0001;
            pressure_in = (i == 0) ? PRESSURE_FULL : lfsr[31:16];
            f = 32'(fan_coeff) * isqrt(pressure_in);
            repeat (30) @(negedge sys_clk);
            rc(IR_PRESSURE, pressure_in, "pressure");
            rc(IR_FLOW_HI, f[31:16], "flow upper");
            rc(IR_FLOW_LO, f[15:0], "flow lower");
            f = 32'(fan_coeff) * 32'h0000_00FF;
            rc(IR_MAXFLOW_HI, f[31:16], "max flow upper");
            rc(IR_MAXFLOW_LO, f[15:0], "max flow lower");
        end
        $display("coefficient flow test done");
        {fan_coeff, speed_mode} = {16'h0000, SPEED_MODE_ON};
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            duct_area = lfsr[15:0];
            speed_in = (i == 0) ? 16'h012D : {7'h00, lfsr[24:16]};
            e = (speed_in > SPEED_MAX) ? SPEED_MAX : speed_in;
            f = 32'(duct_area) * 32'(e);
            repeat (30) @(negedge sys_clk);
            rc(IR_SPEED, e, "air speed");
            rc(IR_FLOW_HI, f[31:16], "area flow upper");
            rc(IR_FLOW_LO, f[15:0], "area flow lower");
            f = 32'(duct_area) * 32'h0000_012C;
            rc(IR_MAXFLOW_HI, f[31:16], "area max upper");
            rc(IR_MAXFLOW_LO, f[15:0], "area max lower");
        end
        speed_mode = 16'h0002;
        repeat (3) @(negedge sys_clk);
        rc(IR_SPEED, 16'h0000, "speed off");
        $display("area flow test done");
        {fan_coeff, pressure_in, speed_mode, speed_in} = {16'h0010, 16'h0100, 32'h0};
        flags(1'b0, 1'b0);
        span_press_hi = 16'h00FF;
        flags(1'b1, 1'b0);
        alarm_press_hi = 16'h00FF;
        flags(1'b1, 1'b1);
        autotune_busy = 1'b1;
        flags(1'b0, 1'b0);
        autotune_busy = 1'b0;
        wide();
        alarm_flow_lo = 32'h0000_0101;
        flags(1'b0, 1'b1);
        wide();
        {speed_mode, speed_in, span_speed_lo} = {SPEED_MODE_ON, 16'h0064, 16'h0065};
        flags(1'b1, 1'b0);
        $display("flag test done");
        for (int i = 0; i < 2; i++) begin
            {feedback_lost, sensor_failed} = (i == 0) ? 2'b10 : 2'b01;
            rc(IR_FB_LOST, {15'h0000, feedback_lost}, "feedback status");
            rc(IR_SENS_FAIL, {15'h0000, sensor_failed}, "sensor status");
            {seen_on, seen_off} = 2'b00;
            repeat (16) begin
                @(negedge sys_clk);
                seen_on = seen_on | (red_led === 1'b1);
                seen_off = seen_off | (red_led === 1'b0);
            end
            check({31'h0, seen_on & seen_off}, 32'h0000_0001, "led flashing");
            {feedback_lost, sensor_failed} = 2'b00;
            repeat (3) @(negedge sys_clk);
            check({31'h0, red_led}, 32'h0000_0000, "led off");
            rc(IR_FB_LOST, 16'h0000, "feedback cleared");
            rc(IR_SENS_FAIL, 16'h0000, "sensor cleared");
        end
        $display("fault test done");
        test_done();
    end
endmodule
